/* File: core/pin_sync.sv */
// Two flip-flop synchroniser for pins from outside the clock domain.
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Pins in, synchronised levels out.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    generate
        if (W < 1) begin : g_bad_w
            $error("W must be at least 1.");
        end
    endgenerate

    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    // The first stage feeds only the second.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            stable_q <= RST_VAL;
        end else begin
            meta_q <= din;
            stable_q <= meta_q;
        end
    end

    assign dout = stable_q;
endmodule : pin_sync

/* File: core/sar_engine.sv */
// Successive approximation engine, one bit resolved per step.
module sar_engine #(
    parameter int RES = 12
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Control side.
    sar_if.engine port
);
    generate
        if (RES < 2) begin : g_bad_res
            $error("RES must be at least 2.");
        end
    endgenerate

    logic [RES-1:0] hold_q;
    logic [RES-1:0] acc_q;
    logic [RES-1:0] bit_q;
    logic [RES-1:0] trial;
    logic keepBit;

    assign trial = acc_q | bit_q;
    assign keepBit = (trial <= hold_q);

    // Straight binary: each kept bit adds its weight to the code.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_q <= '0;
            acc_q <= '0;
            bit_q <= '0;
        end else if (port.start) begin
            hold_q <= port.sample;
            acc_q <= '0;
            bit_q <= {1'b1, {(RES-1){1'b0}}};
        end else if (port.step && bit_q != '0) begin
            acc_q <= keepBit ? trial : acc_q; // R17
            bit_q <= bit_q >> 1;
        end
    end

    assign port.result = acc_q;
    assign port.done = (bit_q == '0);

    a_code_straight: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(port.done) |-> acc_q == hold_q) // R17
        else $error("Finished code differs from held sample.");
endmodule : sar_engine

/* File: core/sar_frame_ctrl.sv */
// Frame control for a serial-output successive-approximation converter.
// Function
// R01: Sample input at chip select falling edge.
// R02: Chip select fall drives data out, MSB first.
// R03: Shift next bit on each falling after rising.
// R04: Sixteen-clock frames return previous frame's result.
// R05: Conversion advances only on clock edges.
// R06: Twelve bits finish on fourteenth rising edge.
// R07: Ten bits finish on eleventh rising edge.
// R08: Eight bits finish on ninth rising edge.
// R09: Early chip select rise keeps sixteen-clock mode.
// R10: Data output released while chip select high.
// R11: Host may stop clock after conversion end.
// R12: Fresh result shifts out from sixteenth falling.
// R13: Thirtieth falling edge selects thirty-two clock mode.
// R14: Thirty-two clock mode returns current sample.
// R15: After that mode, next frame leads zeros.
// R16: Host may stop clock after thirtieth falling.
// R17: Result code is unsigned straight binary.
// R18: Clear counters at fall, judge mode at rise.
`include "sar_frame_defines.svh"
module sar_frame_ctrl #(
    parameter int RES = 12
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Serial link from the host.
    input wire logic csN,
    input wire logic sclk,
    output logic sdoOut,
    output logic sdoOe,
    // Quantised analog input.
    input wire logic [RES-1:0] analogIn,
    // Status.
    output logic sampleTaken,
    output logic convDone,
    output logic acquiring,
    output logic mode32,
    output logic [RES-1:0] resultData
);

    // ************************************************************
    // Parameter check and functions
    // ************************************************************
    generate
        if (RES != 12 && RES != 10 && RES != 8) begin : g_bad_res
            $error("RES must be 12, 10 or 8.");
        end
    endgenerate

    function automatic sar_frame_pkg::edge_cnt_t convEdge(input int res);
        sar_frame_pkg::edge_cnt_t e;
        case (res)
            12: e = `CONV_EDGE_12B;
            10: e = `CONV_EDGE_10B;
            default: e = `CONV_EDGE_8B;
        endcase
        return e;
    endfunction : convEdge
    function automatic sar_frame_pkg::edge_cnt_t incSat(
        input sar_frame_pkg::edge_cnt_t c);
        return (c == `CNT_MAX) ? c : sar_frame_pkg::edge_cnt_t'(c + 1'b1);
    endfunction : incSat
    function automatic sar_frame_pkg::frame_word_t frameWord(
        input logic [RES-1:0] r);
        return {r, {(`FRAME_BITS-RES){1'b0}}};
    endfunction : frameWord

    localparam sar_frame_pkg::edge_cnt_t CONV_EDGE = convEdge(RES);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic csSync;
    logic sclkSync;
    logic [RES-1:0] anaSync;

    // Chip select resets high so no frame is seen before the host acts.
    pin_sync #(
        .W(RES + 2),
        .RST_VAL({1'b1, {(RES+1){1'b0}}})
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din({csN, sclk, analogIn}),
        .dout({csSync, sclkSync, anaSync})
    );

    // ************************************************************
    // Registers
    // ************************************************************
    logic csPrev_q;
    logic sclkPrev_q;
    logic sawRise_q;
    sar_frame_pkg::edge_cnt_t riseCnt_q;
    sar_frame_pkg::edge_cnt_t fallCnt_q;
    sar_frame_pkg::frame_state_e state_q;
    sar_frame_pkg::frame_state_e state_d;
    sar_frame_pkg::frame_word_t shift_q;
    logic sdo_q;
    logic sdoOe_q;
    logic mode32_q;
    logic [RES-1:0] result_q;
    logic sampleTaken_q;
    logic convDone_q;
    logic acquiring_q;

    // ************************************************************
    // Edge decode
    // ************************************************************
    wire inFrame = ~csPrev_q;
    wire csFall = csPrev_q & ~csSync;
    wire csRise = ~csPrev_q & csSync;
    wire rise = inFrame & ~csSync & ~sclkPrev_q & sclkSync;
    wire fall = inFrame & ~csSync & sclkPrev_q & ~sclkSync & sawRise_q;
    wire sar_frame_pkg::edge_cnt_t riseNext = incSat(riseCnt_q);
    wire sar_frame_pkg::edge_cnt_t fallNext = incSat(fallCnt_q);

    // Conversion ends at a fixed rising edge for each resolution.
    wire convEnd = rise && state_q == sar_frame_pkg::FR_CONVERT
                   && riseNext == CONV_EDGE; // R06 R07 R08
    wire freshLoad = fall && fallNext == `FRESH_FALL; // R12
    wire shiftNow = fall && !freshLoad; // R03
    wire keep16 = csRise && state_q == sar_frame_pkg::FR_ACQUIRE
                  && fallCnt_q < `KEEP16_FALL_LIM; // R09
    wire go32 = csRise && fallCnt_q >= `MODE32_FALL; // R13 R16
    logic [RES-1:0] sarResult;
    wire sar_frame_pkg::frame_word_t freshWord = frameWord(sarResult);
    wire sar_frame_pkg::frame_word_t prevWord = frameWord(result_q);
    wire sar_frame_pkg::frame_word_t leadWord =
        mode32_q ? '0 : prevWord; // R04 R15
    wire leadMsb = leadWord[`FRAME_BITS-1];
    wire shiftMsb = shift_q[`FRAME_BITS-1];
    wire freshSrc = convEnd ? freshWord[`FRAME_BITS-1]
                            : prevWord[`FRAME_BITS-1];
    wire sar_frame_pkg::frame_word_t freshPick =
        convEnd ? freshWord : prevWord;

    // ************************************************************
    // Approximation engine
    // ************************************************************
    sar_if #(.RES(RES)) sarBus ();

    assign sarBus.start = csFall; // R01
    assign sarBus.sample = anaSync; // R01
    assign sarBus.step = rise && state_q == sar_frame_pkg::FR_CONVERT; // R05
    assign sarResult = sarBus.result;

    sar_engine #(
        .RES(RES)
    ) u_engine (
        .sys_clk(sys_clk),
        .rst(rst),
        .port(sarBus.engine)
    );

    // ************************************************************
    // Frame state
    // ************************************************************
    // The host may stop the clock once acquiring; nothing waits on it.
    always_comb begin
        state_d = state_q;
        case (state_q)
            sar_frame_pkg::FR_IDLE: begin
                if (csFall) begin
                    state_d = sar_frame_pkg::FR_CONVERT;
                end
            end
            sar_frame_pkg::FR_CONVERT: begin
                if (csRise) begin
                    state_d = sar_frame_pkg::FR_IDLE;
                end else if (convEnd) begin
                    state_d = sar_frame_pkg::FR_ACQUIRE; // R06 R11
                end
            end
            sar_frame_pkg::FR_ACQUIRE: begin
                if (csRise) begin
                    state_d = sar_frame_pkg::FR_IDLE;
                end
            end
            default: begin
                state_d = sar_frame_pkg::FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= sar_frame_pkg::FR_IDLE;
            acquiring_q <= 1'b1;
            csPrev_q <= 1'b1;
            sclkPrev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            acquiring_q <= (state_d != sar_frame_pkg::FR_CONVERT);
            csPrev_q <= csSync;
            sclkPrev_q <= sclkSync;
        end
    end

    // ************************************************************
    // Edge counters
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            riseCnt_q <= '0;
            fallCnt_q <= '0;
            sawRise_q <= 1'b0;
        end else if (csFall) begin
            riseCnt_q <= '0; // R18
            fallCnt_q <= '0; // R18
            sawRise_q <= 1'b0;
        end else begin
            if (rise) begin
                riseCnt_q <= riseNext;
                sawRise_q <= 1'b1;
            end else if (fall) begin
                fallCnt_q <= fallNext;
                sawRise_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Result and mode
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= '0;
            convDone_q <= 1'b0;
            sampleTaken_q <= 1'b0;
        end else begin
            convDone_q <= convEnd;
            sampleTaken_q <= csFall; // R01
            if (convEnd) begin
                result_q <= sarResult; // R14
            end
        end
    end

    // A frame cut before conversion end leaves the mode untouched.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode32_q <= 1'b0;
        end else if (go32) begin
            mode32_q <= 1'b1; // R13 R18
        end else if (keep16) begin
            mode32_q <= 1'b0; // R09 R18
        end
    end

    // ************************************************************
    // Serial data out
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_q <= '0;
            sdo_q <= 1'b0;
            sdoOe_q <= 1'b0;
        end else if (csRise) begin
            sdoOe_q <= 1'b0; // R10
        end else if (csFall) begin
            sdoOe_q <= 1'b1; // R02
            sdo_q <= leadMsb; // R02 R04 R15
            shift_q <= leadWord << 1;
        end else if (freshLoad) begin
            sdo_q <= freshSrc; // R12 R14
            shift_q <= freshPick << 1;
        end else if (shiftNow) begin
            sdo_q <= shiftMsb; // R03
            shift_q <= shift_q << 1;
        end
    end

    assign sdoOut = sdo_q;
    assign sdoOe = sdoOe_q;
    assign sampleTaken = sampleTaken_q;
    assign convDone = convDone_q;
    assign acquiring = acquiring_q;
    assign mode32 = mode32_q;
    assign resultData = result_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence frameOpen;
        csFall ##1 (sdoOe_q && sampleTaken_q);
    endsequence
    sequence zeroLead;
        (!sdo_q && sdoOe_q) [*4];
    endsequence
    a_frame_open: assert property ( // R01
        csFall |-> frameOpen)
        else $error("Frame start did not sample and drive.");
    a_msb_first: assert property ( // R02
        csFall |=> sdo_q == $past(leadMsb))
        else $error("First bit is not the lead word MSB.");
    a_bit_shift: assert property ( // R03
        shiftNow |=> sdo_q == $past(shiftMsb))
        else $error("Falling edge did not shift next bit.");
    a_prev_result: assert property ( // R04
        csFall && !mode32_q |=> sdo_q == $past(result_q[RES-1]))
        else $error("Sixteen-clock frame not led by prior result.");
    a_conv_end: assert property ( // R06
        convEnd |=> convDone_q && state_q == sar_frame_pkg::FR_ACQUIRE
                    && result_q == $past(sarResult))
        else $error("Conversion end not taken at its edge.");
    a_step_gate: assert property ( // R05
        sarBus.step |-> !csSync && state_q == sar_frame_pkg::FR_CONVERT)
        else $error("Conversion stepped outside a frame.");
    a_keep_sixteen: assert property ( // R09
        keep16 |=> !mode32_q)
        else $error("Early rise did not keep sixteen-clock mode.");
    a_tristate_high: assert property ( // R10
        csRise |=> !sdoOe_q [*2])
        else $error("Data output driven with chip select high.");
    a_fresh_msb: assert property ( // R12
        freshLoad |=> sdo_q == $past(freshSrc))
        else $error("Fresh result not started at sixteenth fall.");
    a_mode_thirty: assert property ( // R13
        go32 |=> mode32_q && !sdoOe_q)
        else $error("Thirty-two clock mode not detected.");
    a_zero_lead: assert property ( // R15
        csFall && mode32_q |=> zeroLead)
        else $error("Frame after long mode not led by zeros.");
    a_count_clear: assert property ( // R18
        csFall |=> riseCnt_q == '0 && fallCnt_q == '0)
        else $error("Edge counters not cleared at frame start.");
endmodule : sar_frame_ctrl

/* File: core/sar_frame_defines.svh */
// Frame edge counts and widths for the serial converter frame control.
`ifndef SAR_FRAME_DEFINES_SVH
`define SAR_FRAME_DEFINES_SVH

// ************************************************************
// Widths
// ************************************************************
`define FRAME_BITS 16
`define CNT_W 6
`define CNT_MAX 6'h3f

// ************************************************************
// Edge counts within one chip select low period
// ************************************************************
`define CONV_EDGE_12B 6'h0e
`define CONV_EDGE_10B 6'h0b
`define CONV_EDGE_8B 6'h09
`define FRESH_FALL 6'h10
`define KEEP16_FALL_LIM 6'h1d
`define MODE32_FALL 6'h1e

`endif

/* File: core/sar_frame_pkg.sv */
// Types shared by the serial converter frame control.
`include "sar_frame_defines.svh"

package sar_frame_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_CONVERT,
        FR_ACQUIRE
    } frame_state_e;

    typedef logic [`CNT_W-1:0] edge_cnt_t;
    typedef logic [`FRAME_BITS-1:0] frame_word_t;

endpackage : sar_frame_pkg

/* File: core/sar_if.sv */
// Handshake between the frame control and the approximation engine.
interface sar_if #(
    parameter int RES = 12
);
    logic start;
    logic step;
    logic [RES-1:0] sample;
    logic [RES-1:0] result;
    logic done;

    modport ctrl (output start, output step, output sample,
                  input result, input done);
    modport engine (input start, input step, input sample,
                    output result, output done);
endinterface : sar_if

/* File: verification/sar_adc_serial_frame_ctrl_tb.sv */
// Bench top: three resolutions run side by side under one verdict.
module sar_adc_serial_frame_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk;
    logic rst;
    wire [2:0] done;
    int e12, e10, e8, t12, t10, t8;
    int numErrors = 0;
    int testsRun = 0;
    int w;

    sar_lane #(.RES(12)) lane12 (
        .sys_clk(sys_clk), .rst(rst), .laneDone(done[0]),
        .errCnt(e12), .testCnt(t12)
    );
    sar_lane #(.RES(10)) lane10 (
        .sys_clk(sys_clk), .rst(rst), .laneDone(done[1]),
        .errCnt(e10), .testCnt(t10)
    );
    sar_lane #(.RES(8)) lane8 (
        .sys_clk(sys_clk), .rst(rst), .laneDone(done[2]),
        .errCnt(e8), .testCnt(t8)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic giveVerdict();
        numErrors += e12 + e10 + e8;
        testsRun = t12 + t10 + t8;
        $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : giveVerdict

    // ************************************************************
    // Reset, bounded wait for all lanes, verdict
    // ************************************************************
    initial begin
        rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        w = 0;
        while (done !== 3'b111 && w < 60000) begin
            @(posedge sys_clk);
            w++;
        end
        if (done !== 3'b111) begin
            numErrors++;
            $display("ERROR %0d ns lanes did not finish", $time);
        end
        repeat (2) @(posedge sys_clk);
        giveVerdict();
    end
endmodule : sar_adc_serial_frame_ctrl_tb

/* File: verification/sar_host_model.sv */
// Host side serial master model that frames, clocks and captures the link.
module sar_host_model (
    // Clock.
    input wire logic sys_clk,
    // Frame request from the bench.
    input wire logic go,
    input wire logic [5:0] nClk,
    // Link pins.
    input wire logic sdoOut,
    input wire logic sdoOe,
    output logic csN,
    output logic sclk,
    // Captured frame.
    output logic [31:0] capBits,
    output logic frameDone
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Released line
    // ************************************************************
    logic lastBit = 1'b0;
    logic sdoWire;

    // A released line shows the inverse of its last driven level, so a
    // capture while the device is not driving passes only if the expected bit is that inverse.
    assign sdoWire = sdoOe ? sdoOut : ~lastBit;

    always @(posedge sys_clk) begin
        if (sdoOe === 1'b1) begin
            lastBit <= sdoOut;
        end
    end

    // ************************************************************
    // Frame sequencing
    // ************************************************************
    // The link clock stands low between frames; each cycle rises first.
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        capBits = '0;
        frameDone = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (go === 1'b1) begin
                #1 csN = 1'b0;
                capBits = '0;
                #84;
                for (int k = 0; k < int'(nClk); k++) begin
                    sclk = 1'b1;
                    capBits = {capBits[30:0], sdoWire};
                    #80 sclk = 1'b0;
                    #80;
                end
                csN = 1'b1;
                repeat (12) @(posedge sys_clk);
                #1 frameDone = 1'b1;
                @(posedge sys_clk);
                #1 frameDone = 1'b0;
            end
        end
    end
endmodule : sar_host_model

/* File: verification/sar_lane.sv */
// One frame control instance with its host model, stimulus and checks.
module sar_lane #(
    parameter int RES = 12
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Results.
    output logic laneDone,
    output int errCnt,
    output int testCnt
);
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [31:0] bits;
        logic m32;
        logic [RES-1:0] res;
        logic conv;
    } note_s;

    // Rising edge that ends conversion for each resolution.
    localparam int CONV_RISES = (RES == 12) ? 14 : (RES == 10) ? 11 : 9;

    logic csN, sclk, sdoOut, sdoOe, go, frameDone;
    logic sampleTaken, convDone, acquiring, mode32, m32Exp;
    logic [RES-1:0] analogIn, resultData, prevRes;
    logic [5:0] nClk;
    logic [31:0] capBits, lfsr;
    note_s notes[$];
    note_s got;
    int sampleCnt = 0;
    int convCnt = 0;
    int lens[13] = '{16, 32, 8, 16, 32, 32, 28, 8, 29, 14, 30, 29, 16};

    sar_frame_ctrl #(.RES(RES)) i_sar_frame_ctrl (
        .sys_clk(sys_clk), .rst(rst), .csN(csN), .sclk(sclk),
        .sdoOut(sdoOut), .sdoOe(sdoOe), .analogIn(analogIn),
        .sampleTaken(sampleTaken), .convDone(convDone),
        .acquiring(acquiring), .mode32(mode32), .resultData(resultData)
    );

    sar_host_model i_host (
        .sys_clk(sys_clk), .go(go), .nClk(nClk), .sdoOut(sdoOut),
        .sdoOe(sdoOe), .csN(csN), .sclk(sclk), .capBits(capBits),
        .frameDone(frameDone)
    );

    function automatic logic [31:0] lfsrNext(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsrNext

    task automatic flag(input string msg);
        errCnt++;
        $display("ERROR %0d ns lane %0d: %s", $time, RES, msg);
    endtask : flag

    // ************************************************************
    // Driver: notes the expected frame, then asks the host to run it
    // ************************************************************
    task automatic runFrame(input int n);
        logic [31:0] word;
        note_s nt;
        int w;
        @(posedge sys_clk);
        #1;
        lfsr = lfsrNext(lfsr);
        analogIn = lfsr[RES-1:0];
        word[31:16] = m32Exp ? 16'h0000 : 16'(prevRes) << (16 - RES);
        word[15:0] = 16'(lfsr[RES-1:0]) << (16 - RES);
        nt.bits = '0;
        for (int k = 0; k < n; k++) begin
            nt.bits = {nt.bits[30:0], word[31 - k]};
        end
        // A frame cut before conversion end keeps both mode and result.
        if (n >= CONV_RISES) begin
            if (n >= 30) begin
                m32Exp = 1'b1;
            end else if (n <= 28) begin
                m32Exp = 1'b0;
            end
            prevRes = lfsr[RES-1:0];
        end
        nt.m32 = m32Exp;
        nt.res = prevRes;
        nt.conv = (n >= CONV_RISES);
        notes.push_back(nt);
        repeat (4) @(posedge sys_clk);
        #1 go = 1'b1;
        nClk = 6'(n);
        @(posedge sys_clk);
        #1 go = 1'b0;
        w = 0;
        while (frameDone !== 1'b1 && w < 3000) begin
            @(posedge sys_clk);
            w++;
        end
        if (w >= 3000) begin
            flag("frame never completed");
        end
        $display("Lane %0d: frame of %0d clocks done", RES, n);
    endtask : runFrame

    initial begin
        analogIn = '0;
        go = 1'b0;
        nClk = 6'h00;
        laneDone = 1'b0;
        errCnt = 0;
        testCnt = 0;
        lfsr = 32'h3ac95a4c;
        prevRes = '0;
        m32Exp = 1'b0;
        repeat (8) @(posedge sys_clk);
        foreach (lens[i]) begin
            runFrame(lens[i]);
        end
        laneDone = 1'b1;
    end

    // ************************************************************
    // Monitor: compares each finished frame with the oldest note
    // ************************************************************
    // Pulse counts are cleared per frame, so a stray or missing
    // conversion in any frame shows even when the data look right.
    always @(posedge sys_clk) begin
        if (frameDone === 1'b1 && notes.size() > 0) begin
            got = notes.pop_front();
            testCnt += 7;
            if (capBits !== got.bits) flag("bits");
            if (mode32 !== got.m32) flag("frame mode wrong");
            if (resultData !== got.res) flag("result wrong");
            if (sdoOe !== 1'b0) flag("output not released");
            if (acquiring !== 1'b1) flag("not acquiring");
            if (sampleCnt != 1) flag("sample pulse count");
            if (convCnt != int'(got.conv)) flag("conversion pulses");
            sampleCnt <= 0;
            convCnt <= 0;
        end else begin
            if (sampleTaken === 1'b1) sampleCnt <= sampleCnt + 1;
            if (convDone === 1'b1) convCnt <= convCnt + 1;
        end
    end
endmodule : sar_lane
